/* pcsc_checker.sv */
// Assertions on the register access interface of the status/command block
`timescale 1ns/1ps
module pcsc_checker #(
  parameter logic [23:0] CLASS_CODE = 24'h0a0b0c, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h5a // Arbitrary value
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic cfg_wr, // Write strobe
  input wire logic cfg_rd, // Read strobe
  input wire logic cfg_from_pci, // PCI configuration cycle
  input wire logic [7:0] cfg_addr, // Byte offset
  input wire logic [31:0] cfg_wdata, // Write data
  input wire logic [31:0] cfg_rdata, // Read data
  input wire logic cfg_rvalid // Read data valid
);
  import pcsc_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic [7:0] a_q;
  logic [31:0] cmd_q;
  logic [31:0] seen_q;
  logic [31:0] clr_q;
  logic cs;
  assign cs = cfg_rvalid && a_q == PCSC_OFF_COMMAND_STATUS;
  // Shadow of read address, command bits, flags seen and clears since; clear wins over a same-cycle read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      a_q <= 8'h00;
      cmd_q <= 32'h0;
      seen_q <= 32'h0;
      clr_q <= 32'h0;
    end else begin
      if (cfg_rd) a_q <= cfg_addr;
      if (cfg_wr && cfg_addr == PCSC_OFF_COMMAND_STATUS) cmd_q <= cfg_wdata & PCSC_CMD_MASK;
      if (cs) seen_q <= cfg_rdata & PCSC_W1C_MASK;
      if (cs) clr_q <= 32'h0;
      if (cfg_wr && cfg_from_pci && cfg_addr == PCSC_OFF_COMMAND_STATUS) clr_q <= clr_q | cfg_wdata;
    end
  end
  property p_rvalid_next; cfg_rd |=> cfg_rvalid; endproperty
  a_rvalid_next: assert property (p_rvalid_next) else $error("read without data valid");
  property p_rvalid_cause; cfg_rvalid |-> $past(cfg_rd); endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("data valid without read");
  property p_fixed; cs |-> (cfg_rdata & 32'h06f00000) == PCSC_FIXED_BITS; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");
  property p_zero_bits; cs |-> (cfg_rdata & 32'h000ffca1) == 32'h0; endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved bits not zero");
  property p_cmd; cs |-> (cfg_rdata & PCSC_CMD_MASK) == cmd_q; endproperty
  a_cmd: assert property (p_cmd) else $error("command bits not as written");
  property p_sticky; cs |-> (seen_q & ~clr_q & ~cfg_rdata) == 32'h0; endproperty
  a_sticky: assert property (p_sticky) else $error("flag fell without config clear");
  property p_class; cfg_rvalid && a_q == PCSC_OFF_CLASS_REVISION |-> cfg_rdata == {CLASS_CODE, REVISION}; endproperty
  a_class: assert property (p_class) else $error("class word wrong");
  property p_unmapped; cfg_rvalid && a_q != PCSC_OFF_COMMAND_STATUS && a_q != PCSC_OFF_CLASS_REVISION |->
    cfg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("empty offset not zero");
endmodule

/* pcsc_dev.sv */
// Device end: status flags, command enables and read-only identity words
`timescale 1ns/1ps
module pcsc_dev #(
  parameter logic [23:0] CLASS_CODE = 24'h0a0b0c, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h5a          // Arbitrary value
) (
  input wire logic i_clk_sys,          // System clock
  input wire logic i_rst,              // Synchronous reset
  pcsc_if.dev bus,                     // Register access
  input wire logic i_addr_par_err,     // Address parity error, pulse
  input wire logic i_wdata_par_err,    // Target write data parity error
  input wire logic i_rdata_par_err,    // Master read data parity error
  input wire logic i_perr_seen_wr,     // Target signalled parity error on our write
  input wire logic i_master_abort,     // Master abort end, pulse
  input wire logic i_special_cycle,    // Current master cycle is special
  input wire logic i_target_abort_got, // Target abort seen as master
  input wire logic i_target_abort_sent,// Target abort issued as target
  output logic o_parity_fault_line_n,  // Parity fault line, active low
  output logic o_sys_fault_line_n,     // System fault line, active low
  output logic o_initiator_allow,      // Master operation allowed
  output logic o_target_claim_on,      // Memory claim enable
  output logic o_write_inval_enable,   // May use write-and-invalidate
  output logic o_b2b_any_target_on     // Fast b2b to any target
);
  import pcsc_pkg::*;
  logic [31:0] status_q;
  logic [31:0] cmd_q;
  logic [31:0] set_d;
  logic [31:0] clr_d;
  logic data_perr;
  logic cs_wr;
  logic cfg_clear;
  logic addr_report;
  logic data_report;
  logic [31:0] cmd_d;
  logic [31:0] word_d;
  wire logic [31:0] status_d;

  // Elaboration guards: no bit may be more than one of sticky, stored or fixed
  if ((PCSC_W1C_MASK & PCSC_CMD_MASK) != 32'h0) begin : g_bad_w1c_cmd
    $error("sticky and command masks overlap");
  end
  if ((PCSC_W1C_MASK & PCSC_FIXED_BITS) != 32'h0) begin : g_bad_w1c_fixed
    $error("sticky and fixed masks overlap");
  end
  if ((PCSC_CMD_MASK & PCSC_FIXED_BITS) != 32'h0) begin : g_bad_cmd_fixed
    $error("command and fixed masks overlap");
  end
  // Each flag must sit on a sticky bit, each enable on a stored one
  if (!PCSC_W1C_MASK[PCSC_B_PARITY] || !PCSC_W1C_MASK[PCSC_B_SYSF] || !PCSC_W1C_MASK[PCSC_B_IABORT] ||
      !PCSC_W1C_MASK[PCSC_B_RABORT_GOT] || !PCSC_W1C_MASK[PCSC_B_RABORT_SENT] ||
      !PCSC_W1C_MASK[PCSC_B_IPARITY]) begin : g_bad_flag_pos
    $error("flag position outside sticky mask");
  end
  if (!PCSC_CMD_MASK[PCSC_B_B2B_ANY] || !PCSC_CMD_MASK[PCSC_B_ERR_DRIVE] || !PCSC_CMD_MASK[PCSC_B_PAR_RESP] ||
      !PCSC_CMD_MASK[PCSC_B_WINV] || !PCSC_CMD_MASK[PCSC_B_BCAST] || !PCSC_CMD_MASK[PCSC_B_INIT_ALLOW] ||
      !PCSC_CMD_MASK[PCSC_B_CLAIM]) begin : g_bad_cmd_pos
    $error("enable position outside command mask");
  end
  // Distinct offsets keep the unique read mux free of overlapping items
  if (PCSC_OFF_COMMAND_STATUS == PCSC_OFF_CLASS_REVISION || PCSC_OFF_COMMAND_STATUS == PCSC_OFF_CONFIG_ONE ||
      PCSC_OFF_CLASS_REVISION == PCSC_OFF_CONFIG_ONE) begin : g_bad_offsets
    $error("register offsets collide");
  end

  // Either direction of data transfer counts as a data phase error
  assign data_perr = i_wdata_par_err | i_rdata_par_err;
  assign cs_wr = bus.cfg_wr && bus.cfg_addr == PCSC_OFF_COMMAND_STATUS;

  // Only a configuration cycle may clear flags; internal writes reach enables only
  assign cfg_clear = cs_wr & bus.cfg_from_pci; // R3

  // System line reports address errors only with both enables on
  assign addr_report = i_addr_par_err & cmd_q[PCSC_B_ERR_DRIVE] & cmd_q[PCSC_B_PAR_RESP]; // R13
  // With response off the parity line stays quiet; the flag is still set
  assign data_report = data_perr & cmd_q[PCSC_B_PAR_RESP]; // R2 R15

  // Stored enable positions take write data; fixed and reserved ones stay zero
  assign cmd_d = bus.cfg_wdata & PCSC_CMD_MASK; // R23 R14 R16 R21

  // Hardware set events; set beats a simultaneous clear
  always_comb begin
    set_d = '0;
    set_d[PCSC_B_PARITY] = i_addr_par_err | data_perr; // R1 R15
    set_d[PCSC_B_SYSF] = addr_report; // R4 R13
    set_d[PCSC_B_IABORT] = i_master_abort & ~i_special_cycle; // R5
    set_d[PCSC_B_RABORT_GOT] = i_target_abort_got; // R6
    set_d[PCSC_B_RABORT_SENT] = i_target_abort_sent; // R7
    set_d[PCSC_B_IPARITY] = cmd_q[PCSC_B_PAR_RESP] & (i_rdata_par_err | i_perr_seen_wr); // R9
  end

  // Clear only via PCI configuration write of one
  always_comb begin
    clr_d = '0;
    if (cfg_clear) begin
      clr_d = bus.cfg_wdata & PCSC_W1C_MASK; // R3
    end
  end

  // Next flag word per bit; only sticky positions can ever hold a one
  for (genvar i = 0; i < 32; i++) begin : g_flag
    if (PCSC_W1C_MASK[i]) begin : g_sticky
      // Set is ORed in after the clear, so a same-cycle event survives
      assign status_d[i] = (status_q[i] & ~clr_d[i]) | set_d[i]; // R3
    end else begin : g_none
      assign status_d[i] = 1'b0; // R23
    end
  end

  // Sticky status flags
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      status_q <= PCSC_RESET_STATUS;
    end else begin
      status_q <= status_d; // R3
    end
  end

  // Command enables; fixed and reserved bits never stored
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cmd_q <= PCSC_RESET_STATUS;
    end else if (cs_wr) begin
      cmd_q <= cmd_d; // R23
    end
  end

  // Status/command word: flags, stored enables and fixed capability bits
  assign word_d = status_q | cmd_q | PCSC_FIXED_BITS; // R8 R10 R11

  // Read data valid follows the read strobe by one edge
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bus.cfg_rvalid <= 1'b0;
    end else begin
      bus.cfg_rvalid <= bus.cfg_rd;
    end
  end

  // Read mux, one cycle latency; data holds until the next read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bus.cfg_rdata <= '0;
    end else if (bus.cfg_rd) begin
      unique case (bus.cfg_addr)
        PCSC_OFF_COMMAND_STATUS: bus.cfg_rdata <= word_d; // R8 R10 R11
        PCSC_OFF_CLASS_REVISION: bus.cfg_rdata <= {CLASS_CODE, REVISION}; // R22
        PCSC_OFF_CONFIG_ONE: bus.cfg_rdata <= PCSC_CONFIG_ONE_RESET;
        default: bus.cfg_rdata <= '0;
      endcase
    end
  end

  // Parity line: one-cycle low pulse after a data error, only with response on
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_parity_fault_line_n <= 1'b1;
    end else begin
      o_parity_fault_line_n <= ~data_report; // R2 R15
    end
  end

  // System line pulses with the flag it sets, so flag and line never disagree
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sys_fault_line_n <= 1'b1;
    end else begin
      o_sys_fault_line_n <= ~addr_report; // R4 R13
    end
  end

  // Master enable; the master side must stay idle while this is low
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_initiator_allow <= 1'b0;
    end else begin
      o_initiator_allow <= cmd_q[PCSC_B_INIT_ALLOW]; // R19
    end
  end

  // Memory claim enable, one edge behind the command bit
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_target_claim_on <= 1'b0;
    end else begin
      o_target_claim_on <= cmd_q[PCSC_B_CLAIM]; // R20
    end
  end

  // Write-and-invalidate permission for the master command choice
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_write_inval_enable <= 1'b0;
    end else begin
      o_write_inval_enable <= cmd_q[PCSC_B_WINV]; // R17
    end
  end

  // Fast back-to-back to any target; low limits bursts to one device
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_b2b_any_target_on <= 1'b0;
    end else begin
      o_b2b_any_target_on <= cmd_q[PCSC_B_B2B_ANY]; // R12
    end
  end
endmodule

/* pcsc_host.sv */
// Host end: configuration software issuing single register accesses
`timescale 1ns/1ps
module pcsc_host (
  input wire logic i_clk_sys,       // System clock
  input wire logic i_rst,           // Synchronous reset
  pcsc_if.host bus,                 // Register access
  input wire logic i_req,           // Start access, pulse
  input wire logic i_write,         // 1 write, 0 read
  input wire logic i_from_pci,      // Issue as PCI configuration cycle
  input wire logic [7:0] i_addr,    // Byte offset
  input wire logic [31:0] i_wdata,  // Write data
  output logic [31:0] o_rdata,      // Captured read data
  output logic o_done               // Access finished, pulse
);
  import pcsc_pkg::*;
  logic [31:0] wdata_d;

  // Software keeps zero-only bits zero and never sets broadcast watch
  always_comb begin
    wdata_d = i_wdata;
    if (i_addr == PCSC_OFF_COMMAND_STATUS) begin
      wdata_d = i_wdata & ~(32'h000000a1 | (32'h00000001 << PCSC_B_BCAST)); // R14 R16 R18 R21
    end
  end

  // Drive strobes for one cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bus.cfg_wr <= 1'b0;
      bus.cfg_rd <= 1'b0;
      bus.cfg_from_pci <= 1'b0;
      bus.cfg_addr <= '0;
      bus.cfg_wdata <= '0;
    end else begin
      bus.cfg_wr <= i_req & i_write;
      bus.cfg_rd <= i_req & ~i_write;
      if (i_req) begin
        bus.cfg_from_pci <= i_from_pci;
        bus.cfg_addr <= i_addr;
        bus.cfg_wdata <= wdata_d; // R19
      end
    end
  end

  // Completion
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= bus.cfg_wr | bus.cfg_rvalid;
      if (bus.cfg_rvalid) begin
        o_rdata <= bus.cfg_rdata;
      end
    end
  end
endmodule

/* pcsc_if.sv */
// Interface joining configuration software and the status/command block
`timescale 1ns/1ps
interface pcsc_if;
  logic cfg_wr;          // Write strobe, one cycle
  logic cfg_rd;          // Read strobe, one cycle
  logic cfg_from_pci;    // Access is a PCI configuration cycle
  logic [7:0] cfg_addr;  // Byte offset in header
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid;      // Read data valid, one cycle
  modport dev (input cfg_wr, cfg_rd, cfg_from_pci, cfg_addr, cfg_wdata, output cfg_rdata, cfg_rvalid);
  modport host (output cfg_wr, cfg_rd, cfg_from_pci, cfg_addr, cfg_wdata, input cfg_rdata, cfg_rvalid);
endinterface

/* pcsc_pkg.sv */
// Constants shared by both ends of the configuration status/command block
// Behaviour
// R1 - Parity flag set on every detected parity error
// R2 - Data parity error with response drives fault line
// R3 - Sticky flags cleared only by config write one
// R4 - System fault flag set when fault line driven
// R5 - Master abort as initiator sets flag, not special
// R6 - Target abort received as initiator sets flag
// R7 - Target abort sent as target sets flag
// R8 - Claim speed code reads constant medium
// R9 - Initiator parity flag needs response enable, master
// R10 - Back-to-back capable bit reads constant one
// R11 - Bits 22,21,20 read 0,1,0
// R12 - Any-target back-to-back enable gates master
// R13 - Error line driver enable; address parity needs both
// R14 - Stepping bit reads zero; software writes zero
// R15 - Parity response off only flags, on drives line
// R16 - Palette watch reads zero; software writes zero
// R17 - Write-invalidate enable gates master command choice
// R18 - Software never writes one to broadcast watch
// R19 - No bus mastering unless initiator allow set
// R20 - Target claim enable gates memory recognition
// R21 - Port space bit reads zero; software writes zero
// R22 - Class/revision word: class code and revision
// R23 - Fixed and reserved bits ignore writes
package pcsc_pkg;
  localparam logic [31:0] PCSC_BASE = 32'hfc0a8000;
  localparam logic [7:0] PCSC_OFF_COMMAND_STATUS = 8'h04;
  localparam logic [7:0] PCSC_OFF_CLASS_REVISION = 8'h08;
  localparam logic [7:0] PCSC_OFF_CONFIG_ONE = 8'h0c;
  // Status bit positions
  localparam int PCSC_B_PARITY = 31;
  localparam int PCSC_B_SYSF = 30;
  localparam int PCSC_B_IABORT = 29;
  localparam int PCSC_B_RABORT_GOT = 28;
  localparam int PCSC_B_RABORT_SENT = 27;
  localparam int PCSC_B_IPARITY = 24;
  // Command bit positions
  localparam int PCSC_B_B2B_ANY = 9;
  localparam int PCSC_B_ERR_DRIVE = 8;
  localparam int PCSC_B_PAR_RESP = 6;
  localparam int PCSC_B_WINV = 4;
  localparam int PCSC_B_BCAST = 3;
  localparam int PCSC_B_INIT_ALLOW = 2;
  localparam int PCSC_B_CLAIM = 1;
  // Fixed bits: speed code 01, b2b capable, 66 MHz capable
  localparam logic [31:0] PCSC_FIXED_BITS = 32'h02a00000;
  localparam logic [31:0] PCSC_W1C_MASK = 32'hf9000000;
  localparam logic [31:0] PCSC_CMD_MASK = 32'h0000035e;
  localparam logic [31:0] PCSC_CONFIG_ONE_RESET = 32'h00000000;
  localparam logic [31:0] PCSC_RESET_STATUS = 32'h00000000;
endpackage

/* tb_top.sv */
// Bench joining host and device ends through the access interface
`timescale 1ns/1ps
module tb_top;
  import pcsc_pkg::*;
  logic clk = 0, rst = 1, req = 0, wr = 0, pci = 0;
  logic [7:0] addr = 8'h00, ev = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic done, sn, pn, ia, tc, wi, fb;
  int failures = 0, checked = 0;
  pcsc_if bus ();
  pcsc_host pcsc_host_inst (.i_clk_sys(clk), .i_rst(rst), .bus(bus), .i_req(req), .i_write(wr), .i_from_pci(pci),
    .i_addr(addr), .i_wdata(wd), .o_rdata(rd), .o_done(done));
  pcsc_dev pcsc_dev_inst (.i_clk_sys(clk), .i_rst(rst), .bus(bus), .i_addr_par_err(ev[0]), .i_wdata_par_err(ev[1]),
    .i_rdata_par_err(ev[2]), .i_perr_seen_wr(ev[3]), .i_master_abort(ev[4]), .i_special_cycle(ev[5]),
    .i_target_abort_got(ev[6]), .i_target_abort_sent(ev[7]), .o_parity_fault_line_n(pn), .o_sys_fault_line_n(sn),
    .o_initiator_allow(ia), .o_target_claim_on(tc), .o_write_inval_enable(wi), .o_b2b_any_target_on(fb));
  pcsc_checker pcsc_checker_inst (.i_clk_sys(clk), .i_rst(rst), .cfg_wr(bus.cfg_wr), .cfg_rd(bus.cfg_rd),
    .cfg_from_pci(bus.cfg_from_pci), .cfg_addr(bus.cfg_addr), .cfg_wdata(bus.cfg_wdata),
    .cfg_rdata(bus.cfg_rdata), .cfg_rvalid(bus.cfg_rvalid));
  initial forever #5 clk = ~clk;
  // Verdict and end of run
  task automatic summarize();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Register word read back through the host
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  // Fault lines as {system, parity}
  task automatic chk_lines(input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t lines %b expected %b", $time, got, exp);
    end
  endtask
  // Enables as {initiator, claim, write-invalidate, any-target}
  task automatic chk_enables(input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t enables %b expected %b", $time, got, exp);
    end
  endtask
  // One host access; the wait for done is bounded so a hang ends the run
  task automatic acc(input logic w, input logic p, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    pci <= p;
    addr <= a;
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    for (n = 0; n < 8 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 8) begin
      failures++;
      $display("ERROR %0t access timeout", $time);
      summarize();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, 1'b1, a, 32'h0);
    chk_word(exp, rd);
  endtask
  // One-cycle event, then fault lines checked one edge later as {system, parity}
  task automatic pulse(input logic [7:0] e, input logic [1:0] ln);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 8'h00;
    #1;
    chk_lines(ln, {sn, pn});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h04, 32'h02a00000);
    rdc(8'h08, 32'h0a0b0c5a);
    acc(1'b1, 1'b0, 8'h04, 32'hffffffff);
    rdc(8'h04, 32'h02a00356);
    chk_enables(4'hf, {ia, tc, wi, fb});
    pulse(8'h01, 2'b01);
    pulse(8'h04, 2'b10);
    pulse(8'h02, 2'b10);
    pulse(8'h10, 2'b11);
    pulse(8'h40, 2'b11);
    pulse(8'h80, 2'b11);
    rdc(8'h04, 32'hfba00356);
    acc(1'b1, 1'b0, 8'h04, 32'hffffffff);
    rdc(8'h04, 32'hfba00356);
    acc(1'b1, 1'b1, 8'h04, 32'h10000356);
    rdc(8'h04, 32'heba00356);
    acc(1'b1, 1'b1, 8'h04, 32'hf9000000);
    rdc(8'h04, 32'h02a00000);
    chk_enables(4'h0, {ia, tc, wi, fb});
    pulse(8'h04, 2'b11);
    pulse(8'h30, 2'b11);
    pulse(8'h08, 2'b11);
    rdc(8'h04, 32'h82a00000);
    rdc(8'h0c, 32'h0);
    rdc(8'h40, 32'h0);
    summarize();
  end
endmodule
